// ### design/drive_protection_trip_logic.sv
// Drive protection and trip logic: open-phase, external trip and
// inverter overload with an early warning on the output terminals.
// Assumes an APB master on pclk, asynchronous terminal pins, and
// measurement logic on pclk giving current and phase figures.
//
// What this block does
// - Bit 1 output, bit 2 input phase-loss enable
// - Input loss band 1 to 100 V, default 40
// - Terminal function code 4 gives external trip
// - Mask 0 normally open, 1 normally closed
// - Mask bits 1 to 7 map terminals one-seven
// - Inverse-time trip, 150 percent for one minute
// - Warning at 60 percent, 36 s at 150
// - Output function code 6 drives overload warning
`timescale 1ns/10ps
module drive_protection_trip_logic
	import trip_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES // Cycles per millisecond tick
)
(
	input wire logic pclk, // APB clock, 20 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [6:0] terminal_pins, // Terminals one to seven, 1 = closed
	input wire logic [8:0] current_pct, // Inverter current, percent of rated
	input wire logic output_phase_open, // Output phase missing detected
	input wire logic [6:0] input_ripple_volts, // Input ripple, volts
	output logic relay_one_out, // Relay 1 drive
	output logic relay_two_out, // Relay 2 drive
	output logic open_collector_out, // Open-collector output drive
	output logic trip_stop // Any trip, stop operation
);
	typedef struct packed {
		logic [6:0] sync1;
		logic [6:0] sync2;
		logic [2:1] ph_en;
		logic [6:0] band;
		logic [7:1] pol;
		logic [FUNC_W*NUM_TERM-1:0] in_func;
		logic [FUNC_W*NUM_OUT-1:0] out_func;
		logic ext_trip;
		logic in_loss_trip;
		logic out_loss_trip;
		logic [15:0] tick_cnt;
		logic [31:0] prdata;
		logic [NUM_OUT-1:0] outs;
		logic stop;
	} main_s;

	main_s st_ff;
	main_s nxt_st;
	logic [6:0] term_active;
	logic [6:0] ext_hit;
	logic [NUM_OUT-1:0] out_warn_sel;
	logic tick;
	logic clear;
	logic wr_en;
	logic rd_setup;
	logic mapped;
	logic ol_warn;
	logic ol_trip;
	logic [ACC_W-1:0] ol_acc;
	logic ext_cond;
	logic in_loss_cond;
	logic out_loss_cond;

	// ---------------------------------------------------------------
	// Per-terminal decode, polarity applied first
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TERM; gi++) begin : g_term
			// Closed contact reads 1; a set mask bit inverts it
			assign term_active[gi] = st_ff.sync2[gi] ^ st_ff.pol[gi+1];
			assign ext_hit[gi] = term_active[gi] &&
				(st_ff.in_func[gi*FUNC_W +: FUNC_W] == FUNC_EXT_TRIP);
		end
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
			assign out_warn_sel[gi] = st_ff.out_func[gi*FUNC_W +: FUNC_W] == FUNC_OL_WARN;
		end
	endgenerate

	// ---------------------------------------------------------------
	// Bus strobes and trip conditions
	// ---------------------------------------------------------------
	assign mapped = (paddr <= OFS_ACC) && (paddr[1:0] == 2'h0);
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign clear = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_CLEAR_BIT];
	assign tick = (st_ff.tick_cnt == 16'(TICK_DIV - 1));
	assign ext_cond = |ext_hit;
	assign out_loss_cond = st_ff.ph_en[PH_OUT_BIT] && output_phase_open;
	assign in_loss_cond = st_ff.ph_en[PH_IN_BIT] && (input_ripple_volts > st_ff.band);

	// ---------------------------------------------------------------
	// Next state: sync, registers, trip latches, outputs
	// ---------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = terminal_pins;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.tick_cnt = tick ? 16'h0000 : st_ff.tick_cnt + 16'h0001;
		if (wr_en) begin
			unique case (paddr)
				OFS_CTRL: nxt_st.ph_en = pwdata[PH_IN_BIT:PH_OUT_BIT];
				OFS_BAND: begin
					// Out-of-range writes clamp to the legal band
					if (pwdata[31:0] < 32'(BAND_MIN)) begin
						nxt_st.band = BAND_MIN;
					end else if (pwdata[31:0] > 32'(BAND_MAX)) begin
						nxt_st.band = BAND_MAX;
					end else begin
						nxt_st.band = pwdata[6:0];
					end
				end
				OFS_POL: nxt_st.pol = pwdata[7:1];
				OFS_IN_FUNC: nxt_st.in_func = pwdata[FUNC_W*NUM_TERM-1:0];
				OFS_OUT_FUNC: nxt_st.out_func = pwdata[FUNC_W*NUM_OUT-1:0];
				default: ;
			endcase
		end
		// Clear first, then set, so a live fault survives a clear
		if (clear) begin
			nxt_st.ext_trip = 1'b0;
			nxt_st.in_loss_trip = 1'b0;
			nxt_st.out_loss_trip = 1'b0;
		end
		if (ext_cond) begin
			nxt_st.ext_trip = 1'b1;
		end
		if (in_loss_cond) begin
			nxt_st.in_loss_trip = 1'b1;
		end
		if (out_loss_cond) begin
			nxt_st.out_loss_trip = 1'b1;
		end
		nxt_st.outs = out_warn_sel & {NUM_OUT{ol_warn}};
		nxt_st.stop = nxt_st.ext_trip || nxt_st.in_loss_trip || nxt_st.out_loss_trip || ol_trip;
		// Read data captured in setup so it is stable for the access
		if (rd_setup) begin
			nxt_st.prdata = 32'h0000_0000;
			unique case (paddr)
				OFS_CTRL: nxt_st.prdata[PH_IN_BIT:PH_OUT_BIT] = st_ff.ph_en;
				OFS_BAND: nxt_st.prdata[6:0] = st_ff.band;
				OFS_POL: nxt_st.prdata[7:1] = st_ff.pol;
				OFS_IN_FUNC: nxt_st.prdata[FUNC_W*NUM_TERM-1:0] = st_ff.in_func;
				OFS_OUT_FUNC: nxt_st.prdata[FUNC_W*NUM_OUT-1:0] = st_ff.out_func;
				OFS_STATUS: begin
					nxt_st.prdata[6:0] = term_active;
					nxt_st.prdata[ST_WARN_BIT] = ol_warn;
					nxt_st.prdata[ST_OL_TRIP_BIT] = ol_trip;
					nxt_st.prdata[ST_EXT_TRIP_BIT] = st_ff.ext_trip;
					nxt_st.prdata[ST_OUT_LOSS_BIT] = st_ff.out_loss_trip;
					nxt_st.prdata[ST_IN_LOSS_BIT] = st_ff.in_loss_trip;
				end
				OFS_ACC: nxt_st.prdata[ACC_W-1:0] = ol_acc;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{sync1: 7'h00, sync2: 7'h00, ph_en: PH_EN_RESET, band: BAND_RESET,
				pol: POL_RESET, in_func: '0, out_func: '0, ext_trip: 1'b0,
				in_loss_trip: 1'b0, out_loss_trip: 1'b0, tick_cnt: 16'h0000,
				prdata: 32'h0000_0000, outs: '0, stop: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ---------------------------------------------------------------
	// Overload integrator
	// ---------------------------------------------------------------
	overload_integrator u_overload (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.current_pct(current_pct),
		.clear(clear),
		.warn(ol_warn),
		.trip(ol_trip),
		.acc(ol_acc)
	);

	// Zero-wait slave; unmapped or unaligned addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = st_ff.prdata;
	assign relay_one_out = st_ff.outs[0];
	assign relay_two_out = st_ff.outs[1];
	assign open_collector_out = st_ff.outs[2];
	assign trip_stop = st_ff.stop;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_out_loss;
		@(posedge pclk) disable iff (!presetn)
		(st_ff.ph_en[PH_OUT_BIT] && output_phase_open) |=> st_ff.out_loss_trip ##1 trip_stop;
	endproperty
	a_out_loss: assert property (p_out_loss) else $error("output phase loss not tripped");

	property p_in_loss_off;
		@(posedge pclk) disable iff (!presetn)
		(!st_ff.ph_en[PH_IN_BIT] && !st_ff.in_loss_trip) |=> !st_ff.in_loss_trip;
	endproperty
	a_in_loss_off: assert property (p_in_loss_off) else $error("input loss tripped while disabled");

	property p_band_range;
		@(posedge pclk) disable iff (!presetn)
		(st_ff.band >= BAND_MIN) && (st_ff.band <= BAND_MAX);
	endproperty
	a_band_range: assert property (p_band_range) else $error("band outside 1 to 100 V");

	property p_in_loss;
		@(posedge pclk) disable iff (!presetn)
		(st_ff.ph_en[PH_IN_BIT] && input_ripple_volts > st_ff.band) |=> st_ff.in_loss_trip;
	endproperty
	a_in_loss: assert property (p_in_loss) else $error("input phase loss not tripped");

	property p_ext_trip;
		@(posedge pclk) disable iff (!presetn)
		(st_ff.in_func[3:0] == FUNC_EXT_TRIP && (st_ff.sync2[0] ^ st_ff.pol[1])) |=> st_ff.ext_trip ##1 trip_stop;
	endproperty
	a_ext_trip: assert property (p_ext_trip) else $error("external trip on terminal one missed");

	property p_nc_idle;
		@(posedge pclk) disable iff (!presetn)
		(st_ff.sync2 == st_ff.pol && !st_ff.ext_trip && !ext_cond) |=> !st_ff.ext_trip;
	endproperty
	a_nc_idle: assert property (p_nc_idle) else $error("closed normally-closed contact seen active");

	property p_map_seven;
		@(posedge pclk) disable iff (!presetn)
		(st_ff.in_func[FUNC_W*NUM_TERM-1 -: FUNC_W] == FUNC_EXT_TRIP && st_ff.sync2[6] != st_ff.pol[7]) |=> st_ff.ext_trip;
	endproperty
	a_map_seven: assert property (p_map_seven) else $error("terminal seven uses wrong mask bit");

	property p_relay_warn;
		@(posedge pclk) disable iff (!presetn)
		(st_ff.out_func[3:0] == FUNC_OL_WARN) |=> (relay_one_out == $past(ol_warn));
	endproperty
	a_relay_warn: assert property (p_relay_warn) else $error("relay does not follow overload warning");

	property p_trip_hold;
		@(posedge pclk) disable iff (!presetn)
		(st_ff.ext_trip && !clear) |=> st_ff.ext_trip;
	endproperty
	a_trip_hold: assert property (p_trip_hold) else $error("external trip dropped without reset");

	c_ext_trip: cover property (@(posedge pclk) disable iff (!presetn) $rose(st_ff.ext_trip));
	c_in_loss: cover property (@(posedge pclk) disable iff (!presetn) $rose(st_ff.in_loss_trip));
	c_warn_out: cover property (@(posedge pclk) disable iff (!presetn) $rose(open_collector_out));
endmodule : drive_protection_trip_logic

// ### common/trip_pkg.sv
// Constants for the drive protection and trip logic block.
// Assumes a 20 MHz APB clock; the design files and the bench import this package whole, the contact model does not.
package trip_pkg;
	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_BAND = 8'h04;
	localparam logic [7:0] OFS_POL = 8'h08;
	localparam logic [7:0] OFS_IN_FUNC = 8'h0c;
	localparam logic [7:0] OFS_OUT_FUNC = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_ACC = 8'h18;
	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int PH_OUT_BIT = 1;
	localparam int PH_IN_BIT = 2;
	localparam logic [2:1] PH_EN_RESET = 2'h0;
	localparam logic [6:0] BAND_MIN = 7'h01;
	localparam logic [6:0] BAND_MAX = 7'h64;
	localparam logic [6:0] BAND_RESET = 7'h28;
	localparam logic [7:1] POL_RESET = 7'h00;
	localparam int FUNC_W = 4;
	localparam int NUM_TERM = 7;
	localparam int NUM_OUT = 3;
	localparam logic [3:0] FUNC_EXT_TRIP = 4'h4;
	localparam logic [3:0] FUNC_OL_WARN = 4'h6;
	localparam int ST_WARN_BIT = 7;
	localparam int ST_OL_TRIP_BIT = 8;
	localparam int ST_EXT_TRIP_BIT = 9;
	localparam int ST_OUT_LOSS_BIT = 10;
	localparam int ST_IN_LOSS_BIT = 11;
	// ---------------------------------------------------------------
	// Timing and overload figures
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam logic [8:0] RATED_PCT = 9'h064;
	localparam logic [8:0] ALLOWED_PCT = 9'h096;
	localparam int ALLOWED_S = 60;
	localparam int WARN_PCT = 60;
	localparam int ACC_W = 22;
	localparam logic [ACC_W-1:0] TRIP_LEVEL = ACC_W'((150 - 100) * ALLOWED_S * 1000);
	localparam logic [ACC_W-1:0] WARN_LEVEL = ACC_W'((150 - 100) * ALLOWED_S * 1000 * WARN_PCT / 100);
endpackage : trip_pkg

// ### design/overload_integrator.sv
// Inverse-time overload integrator: heat accumulator, warning and trip.
// Assumes a one-cycle tick every millisecond and a current figure in
// percent of rated current from logic on the same clock.
`timescale 1ns/10ps
module overload_integrator
	import trip_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic tick, // Millisecond enable pulse
	input wire logic [8:0] current_pct, // Current, percent of rated
	input wire logic clear, // Trip reset pulse
	output logic warn, // Overload warning level
	output logic trip, // Latched overload trip
	output logic [ACC_W-1:0] acc // Heat accumulator
);
	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic warn;
		logic trip;
	} ol_s;

	ol_s st_ff;
	ol_s nxt_st;
	logic [8:0] excess;
	logic [8:0] relief;
	logic [ACC_W-1:0] sum;

	// ---------------------------------------------------------------
	// Accumulate excess above rated, relax below it
	// ---------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		excess = current_pct - RATED_PCT;
		relief = RATED_PCT - current_pct;
		sum = st_ff.acc + {{(ACC_W-9){1'b0}}, excess};
		if (tick) begin
			if (current_pct > RATED_PCT) begin
				// Saturate so a long overload cannot wrap the count
				nxt_st.acc = (sum > TRIP_LEVEL) ? TRIP_LEVEL : sum;
			end else if (st_ff.acc > {{(ACC_W-9){1'b0}}, relief}) begin
				nxt_st.acc = st_ff.acc - {{(ACC_W-9){1'b0}}, relief};
			end else begin
				nxt_st.acc = '0;
			end
		end
		nxt_st.warn = nxt_st.acc >= WARN_LEVEL;
		// Set wins over a clear in the same cycle
		if (clear) begin
			nxt_st.trip = 1'b0;
		end
		if (nxt_st.acc >= TRIP_LEVEL) begin
			nxt_st.trip = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign warn = st_ff.warn;
	assign trip = st_ff.trip;
	assign acc = st_ff.acc;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_ol_trip_level;
		@(posedge pclk) disable iff (!presetn)
		(acc >= TRIP_LEVEL) |-> trip;
	endproperty
	a_ol_trip_level: assert property (p_ol_trip_level) else $error("overload trip missing at limit");

	property p_ol_accumulate;
		@(posedge pclk) disable iff (!presetn)
		(tick && current_pct == ALLOWED_PCT && acc < WARN_LEVEL) |=> (acc == $past(acc) + 22'd50);
	endproperty
	a_ol_accumulate: assert property (p_ol_accumulate) else $error("wrong heat step at 150 percent");

	property p_ol_warn;
		@(posedge pclk) disable iff (!presetn)
		warn == (acc >= WARN_LEVEL);
	endproperty
	a_ol_warn: assert property (p_ol_warn) else $error("warning not at 60 percent of heat");

	property p_ol_warn_before_trip;
		@(posedge pclk) disable iff (!presetn)
		$rose(trip) && !$past(clear) |-> $past(warn);
	endproperty
	a_ol_warn_before_trip: assert property (p_ol_warn_before_trip) else $error("trip without prior warning");

	c_ol_trip: cover property (@(posedge pclk) disable iff (!presetn) $rose(trip));
endmodule : overload_integrator

// ### verification/contact_bank.sv
// Behavioural model of the external contacts on the seven input terminals.
// Assumes the bench raises a trip request per terminal just after an edge.
`timescale 1ns/10ps
module contact_bank (
	input wire logic pclk, // Bench clock
	input wire logic [6:0] trip_req, // Trip wanted, one bit per terminal
	input wire logic [6:0] nc_wiring, // 1 = normally-closed trip source
	output logic [6:0] terminal_pins // 1 = contact closed
);
	// Contacts move just after an edge; a closed-type source opens to trip
	always_ff @(posedge pclk) begin
		terminal_pins <= trip_req ^ nc_wiring;
	end
endmodule : contact_bank

// ### verification/drive_protection_trip_logic_test.sv
// Self-checking bench for the protection and trip block.
// Assumes the APB slave answers with no wait states and a 1 ms tick of 4 cycles.
`timescale 1ns/10ps
module drive_protection_trip_logic_test
	import trip_pkg::*;
;
	typedef struct packed {logic rd; logic [31:0] data; logic err;} note_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, output_phase_open;
	logic relay_one_out, relay_two_out, open_collector_out, trip_stop;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic [6:0] terminal_pins, input_ripple_volts, trip_req, nc_wiring;
	logic [8:0] current_pct;
	logic [31:0] band_in [5] = '{32'h0, 32'hc8, 32'h1, 32'h64, 32'h28};
	logic [31:0] band_out [5] = '{32'h1, 32'h64, 32'h1, 32'h64, 32'h28};
	note_s notes[$];
	note_s n;
	int miscompares = 0;
	int check_count = 0;
	int cyc;
	time t0;
	// ----------------------------------------------------------------
	// Design, far-side model and clock
	// ----------------------------------------------------------------
	drive_protection_trip_logic #(.TICK_DIV(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .terminal_pins(terminal_pins), .current_pct(current_pct),
		.output_phase_open(output_phase_open), .input_ripple_volts(input_ripple_volts),
		.relay_one_out(relay_one_out), .relay_two_out(relay_two_out),
		.open_collector_out(open_collector_out), .trip_stop(trip_stop));
	contact_bank u_contacts (.pclk(pclk), .trip_req(trip_req), .nc_wiring(nc_wiring),
		.terminal_pins(terminal_pins));
	initial begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// Compare, report and bus tasks
	// ----------------------------------------------------------------
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	task check_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : check_word
	task check_pin(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask : check_pin
	// One transfer; the expected answer is noted before the bus moves
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic err);
		int i;
		notes.push_back('{!w, e, err});
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		psel <= 0;
		penable <= 0;
		if (i == 20) begin
			miscompares++;
			$display("mismatch at %0t: no ready", $time);
			print_verdict;
		end
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, e, 1'b0);
	endtask : rd
	task settle(input int k);
		repeat (k) @(negedge pclk);
	endtask : settle
	// Bounded wait on the stop output, checked where it has settled
	task wait_trip(input logic e, input int lim);
		for (int i = 0; i < lim && trip_stop !== e; i++) @(negedge pclk);
		check_pin(trip_stop, e);
	endtask : wait_trip
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	// Bus watcher: oldest note against each completed transfer
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			n = notes.pop_front();
			check_pin(pslverr, n.err);
			if (n.rd) check_word(prdata, n.data);
		end
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		miscompares++;
		$display("mismatch at %0t: run timed out", $time);
		print_verdict;
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, output_phase_open} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		current_pct = 9'h064;
		input_ripple_volts = 7'h00;
		trip_req = 7'h00;
		nc_wiring = 7'h00;
		rnd = 32'h41c8;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		rd(OFS_CTRL, 32'h0);
		rd(OFS_BAND, 32'(BAND_RESET));
		rd(OFS_POL, 32'h0);
		apb(1'b0, 8'h1c, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 8'h22, 32'hff, 32'h0, 1'b1);
		for (int k = 0; k < 5; k++) begin
			wr(OFS_BAND, band_in[k]);
			rd(OFS_BAND, band_out[k]);
		end
		// Loss conditions present while both enables are off
		@(posedge pclk);
		output_phase_open <= 1;
		input_ripple_volts <= 7'h64;
		settle(8);
		check_pin(trip_stop, 1'b0);
		wr(OFS_CTRL, 32'h2);
		wait_trip(1'b1, 8);
		rd(OFS_STATUS, 32'h400);
		@(posedge pclk);
		output_phase_open <= 0;
		input_ripple_volts <= 7'h28;
		wr(OFS_CTRL, 32'h5);
		wait_trip(1'b0, 8);
		settle(6);
		check_pin(trip_stop, 1'b0);
		@(posedge pclk);
		input_ripple_volts <= 7'h29;
		wait_trip(1'b1, 8);
		rd(OFS_STATUS, 32'h800);
		@(posedge pclk);
		input_ripple_volts <= 7'h00;
		wr(OFS_CTRL, 32'h1);
		wait_trip(1'b0, 8);
		// External trip on every terminal, random contact type
		for (int t = 0; t < 7; t++) begin
			rnd = xs(rnd);
			@(posedge pclk);
			nc_wiring <= 7'(rnd[0]) << t;
			wr(OFS_POL, 32'(rnd[0]) << (t + 1));
			wr(OFS_IN_FUNC, 32'h4 << (4 * t));
			settle(6);
			check_pin(trip_stop, 1'b0);
			@(posedge pclk);
			trip_req <= 7'h1 << t;
			wait_trip(1'b1, 10);
			rd(OFS_STATUS, (32'h1 << t) | 32'h200);
			@(posedge pclk);
			trip_req <= 7'h00;
			settle(4);
			check_pin(trip_stop, 1'b1);
			wr(OFS_CTRL, 32'h1);
			wait_trip(1'b0, 8);
			wr(OFS_IN_FUNC, 32'h5 << (4 * t));
			@(posedge pclk);
			trip_req <= 7'h1 << t;
			settle(8);
			check_pin(trip_stop, 1'b0);
			@(posedge pclk);
			trip_req <= 7'h00;
		end
		// Overload: warning first, then the trip
		wr(OFS_OUT_FUNC, 32'h606);
		// Eight cycles span exactly two ticks whatever the divider phase
		@(posedge pclk);
		current_pct <= ALLOWED_PCT;
		repeat (8) @(posedge pclk);
		current_pct <= RATED_PCT;
		rd(OFS_ACC, 32'(2 * (ALLOWED_PCT - RATED_PCT)));
		@(posedge pclk);
		current_pct <= 9'h000;
		repeat (8) @(posedge pclk);
		current_pct <= RATED_PCT;
		rd(OFS_ACC, 32'h0);
		@(posedge pclk);
		current_pct <= 9'h1ff;
		t0 = $time;
		for (int i = 0; i < 40000 && relay_one_out !== 1'b1; i++) @(negedge pclk);
		cyc = int'(($time - t0) / CLK_PERIOD_NS);
		check_pin(logic'(cyc >= 4379 * 4 && cyc <= 4381 * 4 + 8), 1'b1);
		check_pin(open_collector_out, 1'b1);
		check_pin(relay_two_out, 1'b0);
		check_pin(trip_stop, 1'b0);
		rd(OFS_STATUS, 32'h80);
		for (int i = 0; i < 40000 && trip_stop !== 1'b1; i++) @(negedge pclk);
		cyc = int'(($time - t0) / CLK_PERIOD_NS);
		check_pin(logic'(cyc >= 7299 * 4 && cyc <= 7301 * 4 + 8), 1'b1);
		rd(OFS_STATUS, 32'h180);
		@(posedge pclk);
		current_pct <= 9'h000;
		settle(12);
		wr(OFS_CTRL, 32'h1);
		wait_trip(1'b0, 8);
		check_pin(relay_one_out, 1'b1);
		print_verdict;
	end
endmodule : drive_protection_trip_logic_test
